// file: rtl/pidc_loop.sv
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
// How it works
// R1: Selected channel is driven by controller command.
// R2: One iteration per configured millisecond period.
// R3: Profile codes: single, dual, setpoint, over, under.
// R4: Target and feedback scaled by own ranges.
// R5: Single output clamps command to 0..100%.
// R6: Dual output clamps command to -100..100%.
// R7: Setpoint profile forces and locks constant target.
// R8: Constant target clamped to feedback range.
// R9: Over and under profiles clamp to 0..100%.
// R10: Error is target minus feedback.
// R11: Error inside dead-band becomes zero.
// R12: Output is P plus I plus D.
// R13: Running error sum times integral gain.
// R14: Integral gain Ki*T/Ti, zero when Ti zero.
// R15: Derivative gain Kd*Td/T on error difference.
// R16: Period in seconds is milliseconds times 0.001.
// R17: Event codes accept 0..21 and 31 only.
// R18: Event codes stored independently, never paired.
// R19: Reset or activation clears sum and previous error.
// R20: Fixed point with saturation, no wrapping.
module pidc_loop #(
   parameter int unsigned CYC_PER_MS = pidc_pkg::TICK_CYC
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Source blocks on the same clock.
   input wire logic signed [15:0] target_value,
   input wire logic signed [15:0] feedback_value,
   input wire logic signed [15:0] chan_direct_cmd,
   // Controller results.
   output logic signed [15:0] pid_cmd,
   output logic signed [15:0] chan_cmd,
   output logic iter_done
);

   pidc_pkg::pidc_state_t s;
   pidc_pkg::pidc_state_t n;
   logic [pidc_pkg::CODE_W-1:0] code_q;
   logic code_we;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers.

   // Scales a value into percent of its source range, clamped to it.
   function automatic logic signed [15:0] to_pct(input logic signed [15:0] x,
                                                 input logic signed [15:0] lo,
                                                 input logic signed [15:0] hi);
      logic signed [31:0] span;
      logic signed [31:0] ofs;
      span = 32'(hi) - 32'(lo);
      ofs = 32'(x) - 32'(lo);
      if (span <= 0) begin
         return '0;
      end
      if (ofs < 0) begin
         ofs = 0;
      end
      if (ofs > span) begin
         ofs = span;
      end
      return 16'((ofs * 32'(pidc_pkg::PCT_ONE)) / span); // [R4] [R8]
   endfunction

   // Saturates a wide value into a range.
   function automatic logic signed [63:0] sat(input logic signed [63:0] v,
                                              input logic signed [63:0] lo,
                                              input logic signed [63:0] hi);
      if (v < lo) begin
         return lo; // [R20]
      end
      if (v > hi) begin
         return hi; // [R20]
      end
      return v;
   endfunction

   // Tells whether a byte address holds a register.
   function automatic logic is_code(input logic [7:0] a);
      return (a[7:5] == pidc_pkg::OFS_CODE_BASE[7:5]) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      return is_code(a) || ((a <= pidc_pkg::OFS_SUM) && (a[1:0] == 2'h0));
   endfunction

   // Accepts only the defined event codes.
   function automatic logic code_ok(input logic [31:0] d);
      return (d[31:5] == '0) && ((d[4:0] <= pidc_pkg::CODE_MAX_RUN) ||
                                 (d[4:0] == pidc_pkg::CODE_EXISTS)); // [R17]
   endfunction

   // Magnitude of an error, for the dead-band test.
   function automatic logic signed [16:0] mag(input logic signed [16:0] v);
      return (v < 0) ? -v : v; // [R11]
   endfunction

   // Lowest command that a response profile may give.
   function automatic logic signed [63:0] floor_of(input pidc_pkg::pidc_kind_t k);
      if (k == pidc_pkg::KIND_DUAL) begin
         return -64'(pidc_pkg::PCT_ONE); // [R6]
      end
      return 64'sh0; // [R5] [R8] [R9]
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Loop gains.

   // Integral gain Ki*T/Ti as Q.16, with T = ms/1000 and Q8.8 operands.
   function automatic logic [31:0] igain(input logic [15:0] ki,
                                         input logic [15:0] ti,
                                         input logic [15:0] ms);
      logic [63:0] num;
      logic [63:0] den;
      num = (64'(ki) * 64'(ms)) << pidc_pkg::IGAIN_FRAC;
      den = 64'(pidc_pkg::MS_PER_S) * 64'(ti); // [R16]
      if (ti == 16'h0000) begin
         return 32'h0; // [R14]
      end
      return 32'(sat(64'(num / den), 64'sh0, 64'sh00000000ffffffff)); // [R14]
   endfunction

   // Derivative gain Kd*Td/T as Q8.8, with T = ms/1000.
   function automatic logic [31:0] dgain(input logic [15:0] kd,
                                         input logic [15:0] td,
                                         input logic [15:0] ms);
      logic [63:0] num;
      logic [63:0] den;
      num = 64'(kd) * 64'(td) * 64'(pidc_pkg::MS_PER_S);
      den = 64'(ms) << pidc_pkg::GAIN_FRAC; // [R16]
      if (ms == 16'h0000) begin
         return 32'h0;
      end
      return 32'(sat(64'(num / den), 64'sh0, 64'sh00000000ffffffff)); // [R15]
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Event code store.

   assign code_we = psel && penable && pwrite && is_code(paddr) && code_ok(pwdata);

   pidc_code_mem #(
      .DEPTH(pidc_pkg::EVENT_COUNT),
      .WIDTH(pidc_pkg::CODE_W)
   ) u_code_mem (
      .pclk(pclk),
      .presetn(presetn),
      .we(code_we),
      .waddr(paddr[4:2]),
      .wdata(pwdata[4:0]),
      .raddr(paddr[4:2]),
      .rdata_q(code_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Bus answers.

   assign pready = 1'b1;
   assign pslverr = psel && penable &&
                    (!is_mapped(paddr) || (pwrite && is_code(paddr) && !code_ok(pwdata)));
   assign prdata = s.rd_code ? {27'h0, code_q} : s.rdata;
   assign pid_cmd = s.cmd;
   assign chan_cmd = s.chan;
   assign iter_done = s.done;

   ////////////////////////////////////////////////////////////////////////////
   // Next state.

   always_comb begin
      logic wr;
      logic due;
      logic signed [16:0] e;
      logic signed [63:0] e64;
      logic signed [63:0] sum64;
      logic signed [63:0] pid64;
      logic signed [63:0] lo64;
      wr = psel && penable && pwrite;
      due = 1'b0;
      e = '0;
      e64 = '0;
      sum64 = '0;
      pid64 = '0;
      lo64 = '0;
      n = s;
      n.done = 1'b0;
      n.en_q = s.cfg.en;

      // Register reads are captured in the setup phase.
      if (psel && !penable) begin
         n.rd_code = is_code(paddr);
         case (paddr)
            pidc_pkg::OFS_CTRL: n.rdata = {26'h0, s.cfg.osrc, s.cfg.tsel, s.cfg.kind, s.cfg.en};
            pidc_pkg::OFS_PERIOD: n.rdata = {16'h0, s.cfg.period_ms};
            pidc_pkg::OFS_DEADBAND: n.rdata = {16'h0, s.cfg.deadband};
            pidc_pkg::OFS_GAIN_G: n.rdata = {16'h0, s.cfg.g};
            pidc_pkg::OFS_GAIN_KI: n.rdata = {16'h0, s.cfg.ki};
            pidc_pkg::OFS_TIME_TI: n.rdata = {16'h0, s.cfg.ti};
            pidc_pkg::OFS_GAIN_KD: n.rdata = {16'h0, s.cfg.kd};
            pidc_pkg::OFS_TIME_TD: n.rdata = {16'h0, s.cfg.td};
            pidc_pkg::OFS_TGT_MIN: n.rdata = 32'(s.cfg.tmin);
            pidc_pkg::OFS_TGT_MAX: n.rdata = 32'(s.cfg.tmax);
            pidc_pkg::OFS_FB_MIN: n.rdata = 32'(s.cfg.fmin);
            pidc_pkg::OFS_FB_MAX: n.rdata = 32'(s.cfg.fmax);
            pidc_pkg::OFS_CONST: n.rdata = 32'(s.cfg.cval);
            pidc_pkg::OFS_STATUS: n.rdata = {15'h0, s.fsm != pidc_pkg::ST_IDLE, s.cmd};
            pidc_pkg::OFS_SUM: n.rdata = 32'(s.sum);
            default: n.rdata = 32'h0;
         endcase
      end

      // Register writes take effect at the access edge.
      if (wr) begin
         case (paddr)
            pidc_pkg::OFS_CTRL: begin
               n.cfg.en = pwdata[pidc_pkg::CTRL_EN_BIT];
               n.cfg.tsel = pwdata[pidc_pkg::CTRL_TSEL_BIT];
               n.cfg.osrc = pwdata[pidc_pkg::CTRL_OSRC_BIT];
               if (pwdata[pidc_pkg::CTRL_KIND_LSB+:3] <= pidc_pkg::KIND_UNDER) begin
                  n.cfg.kind = pidc_pkg::pidc_kind_t'(pwdata[pidc_pkg::CTRL_KIND_LSB+:3]); // [R3]
               end
            end
            pidc_pkg::OFS_PERIOD: n.cfg.period_ms = pwdata[15:0];
            pidc_pkg::OFS_DEADBAND: n.cfg.deadband = pwdata[15:0];
            pidc_pkg::OFS_GAIN_G: n.cfg.g = pwdata[15:0];
            pidc_pkg::OFS_GAIN_KI: n.cfg.ki = pwdata[15:0];
            pidc_pkg::OFS_TIME_TI: n.cfg.ti = pwdata[15:0];
            pidc_pkg::OFS_GAIN_KD: n.cfg.kd = pwdata[15:0];
            pidc_pkg::OFS_TIME_TD: n.cfg.td = pwdata[15:0];
            pidc_pkg::OFS_TGT_MIN: n.cfg.tmin = pwdata[15:0];
            pidc_pkg::OFS_TGT_MAX: n.cfg.tmax = pwdata[15:0];
            pidc_pkg::OFS_FB_MIN: n.cfg.fmin = pwdata[15:0];
            pidc_pkg::OFS_FB_MAX: n.cfg.fmax = pwdata[15:0];
            pidc_pkg::OFS_CONST: n.cfg.cval = pwdata[15:0];
            default: n.cfg = n.cfg;
         endcase
      end
      if (n.cfg.kind == pidc_pkg::KIND_SETPT) begin
         n.cfg.tsel = 1'b1; // [R7]
      end

      // Millisecond tick and loop period.
      if (!s.cfg.en) begin
         n.tick_cnt = '0;
         n.ms_cnt = '0;
      end else if (s.tick_cnt >= CYC_PER_MS - 1) begin
         n.tick_cnt = '0;
         if ((s.ms_cnt >= s.cfg.period_ms - 16'h0001) || (s.cfg.period_ms == 16'h0000)) begin
            n.ms_cnt = '0;
            due = 1'b1; // [R2]
         end else begin
            n.ms_cnt = s.ms_cnt + 16'h0001;
         end
      end else begin
         n.tick_cnt = s.tick_cnt + 32'h1;
      end

      // Iteration sequence.
      case (s.fsm)
         pidc_pkg::ST_IDLE: begin
            if (due) begin
               n.fsm = pidc_pkg::ST_SCALE;
            end
         end
         pidc_pkg::ST_SCALE: begin
            if (s.cfg.tsel) begin
               n.tp = to_pct(s.cfg.cval, s.cfg.fmin, s.cfg.fmax); // [R7] [R8]
            end else begin
               n.tp = to_pct(target_value, s.cfg.tmin, s.cfg.tmax); // [R4]
            end
            n.fp = to_pct(feedback_value, s.cfg.fmin, s.cfg.fmax); // [R4]
            n.ig = igain(s.cfg.ki, s.cfg.ti, s.cfg.period_ms); // [R14]
            n.dg = dgain(s.cfg.kd, s.cfg.td, s.cfg.period_ms); // [R15]
            n.fsm = pidc_pkg::ST_CALC;
         end
         pidc_pkg::ST_CALC: begin
            e = 17'(s.tp) - 17'(s.fp); // [R10]
            if (mag(e) < $signed({1'b0, s.cfg.deadband})) begin
               e = '0; // [R11]
            end
            e64 = 64'(e);
            sum64 = sat(64'(s.sum) + e64, -pidc_pkg::SUM_LIMIT, pidc_pkg::SUM_LIMIT); // [R13]
            pid64 = ((e64 * $signed({48'h0, s.cfg.g})) >>> pidc_pkg::GAIN_FRAC) // [R12]
                  + ((sum64 * $signed({32'h0, s.ig})) >>> pidc_pkg::IGAIN_FRAC) // [R13]
                  + (((e64 - 64'(s.err_prev)) * $signed({32'h0, s.dg}))
                     >>> pidc_pkg::GAIN_FRAC); // [R15]
            lo64 = floor_of(s.cfg.kind); // [R5] [R6]
            if (s.cfg.kind == pidc_pkg::KIND_OVER) begin
               pid64 = -pid64; // [R9]
            end
            n.cmd = 16'(sat(pid64, lo64, 64'(pidc_pkg::PCT_ONE))); // [R20]
            n.sum = 24'(sum64);
            n.err_prev = e;
            n.done = 1'b1;
            n.fsm = pidc_pkg::ST_IDLE;
         end
         default: n.fsm = pidc_pkg::ST_IDLE;
      endcase

      // A disabled loop finishes no iteration and keeps its command.
      if (!s.cfg.en) begin
         n.fsm = pidc_pkg::ST_IDLE;
         n.cmd = s.cmd;
         n.sum = s.sum;
         n.err_prev = s.err_prev;
         n.done = 1'b0;
      end

      // Activation starts a fresh loop history.
      if (s.cfg.en && !s.en_q) begin
         n.sum = '0; // [R19]
         n.err_prev = '0; // [R19]
         n.fsm = pidc_pkg::ST_IDLE;
      end

      // Physical output source selection.
      n.chan = s.cfg.osrc ? s.cmd : chan_direct_cmd; // [R1]
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register.

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0; // [R19]
         s.cfg.kind <= pidc_pkg::KIND_SINGLE;
         s.cfg.period_ms <= pidc_pkg::RST_PERIOD_MS;
         s.cfg.deadband <= pidc_pkg::RST_ZERO;
         s.cfg.g <= pidc_pkg::RST_GAIN;
         s.cfg.tmax <= pidc_pkg::RST_RANGE_MAX;
         s.cfg.fmax <= pidc_pkg::RST_RANGE_MAX;
         s.fsm <= pidc_pkg::ST_IDLE;
      end else begin
         s <= n;
      end
   end

endmodule

// file: rtl/pidc_pkg.sv
package pidc_pkg;

   // One loop tick is one millisecond of the bus clock.
   localparam int unsigned TICK_NS = 1000000;
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
   localparam int unsigned MS_PER_S = 1000;

   // Diagnostic event code store.
   localparam int unsigned EVENT_COUNT = 8;
   localparam int unsigned CODE_W = 5;
   localparam logic [4:0] CODE_MAX_RUN = 5'h15;
   localparam logic [4:0] CODE_EXISTS = 5'h1f;
   localparam logic [4:0] RST_CODE = 5'h00;

   // Register byte offsets.
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PERIOD = 8'h04;
   localparam logic [7:0] OFS_DEADBAND = 8'h08;
   localparam logic [7:0] OFS_GAIN_G = 8'h0c;
   localparam logic [7:0] OFS_GAIN_KI = 8'h10;
   localparam logic [7:0] OFS_TIME_TI = 8'h14;
   localparam logic [7:0] OFS_GAIN_KD = 8'h18;
   localparam logic [7:0] OFS_TIME_TD = 8'h1c;
   localparam logic [7:0] OFS_TGT_MIN = 8'h20;
   localparam logic [7:0] OFS_TGT_MAX = 8'h24;
   localparam logic [7:0] OFS_FB_MIN = 8'h28;
   localparam logic [7:0] OFS_FB_MAX = 8'h2c;
   localparam logic [7:0] OFS_CONST = 8'h30;
   localparam logic [7:0] OFS_STATUS = 8'h34;
   localparam logic [7:0] OFS_SUM = 8'h38;
   localparam logic [7:0] OFS_CODE_BASE = 8'h40;

   // Control and status register fields.
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_KIND_LSB = 1;
   localparam int unsigned CTRL_TSEL_BIT = 4;
   localparam int unsigned CTRL_OSRC_BIT = 5;
   localparam int unsigned STATUS_BUSY_BIT = 16;

   // Fixed point: 100 % is 4096, gains are Q8.8, the integral gain is Q.16.
   localparam logic signed [15:0] PCT_ONE = 16'sh1000;
   localparam int unsigned GAIN_FRAC = 8;
   localparam int unsigned IGAIN_FRAC = 16;
   localparam logic signed [63:0] SUM_LIMIT = 64'sh00000000007fffff;

   // Values after reset.
   localparam logic [15:0] RST_PERIOD_MS = 16'h000a;
   localparam logic [15:0] RST_GAIN = 16'h0100;
   localparam logic [15:0] RST_ZERO = 16'h0000;
   localparam logic [15:0] RST_RANGE_MAX = 16'h03e8;

   typedef enum logic [2:0] {
      KIND_SINGLE = 3'h0,
      KIND_DUAL = 3'h1,
      KIND_SETPT = 3'h2,
      KIND_OVER = 3'h3,
      KIND_UNDER = 3'h4
   } pidc_kind_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_SCALE = 2'h1,
      ST_CALC = 2'h2
   } pidc_fsm_t;

   typedef struct packed {
      logic en;
      pidc_kind_t kind;
      logic tsel;
      logic osrc;
      logic [15:0] period_ms;
      logic [15:0] deadband;
      logic [15:0] g;
      logic [15:0] ki;
      logic [15:0] ti;
      logic [15:0] kd;
      logic [15:0] td;
      logic signed [15:0] tmin;
      logic signed [15:0] tmax;
      logic signed [15:0] fmin;
      logic signed [15:0] fmax;
      logic signed [15:0] cval;
   } pidc_cfg_t;

   typedef struct packed {
      pidc_cfg_t cfg;
      pidc_fsm_t fsm;
      logic en_q;
      logic [31:0] tick_cnt;
      logic [15:0] ms_cnt;
      logic signed [15:0] tp;
      logic signed [15:0] fp;
      logic [31:0] ig;
      logic [31:0] dg;
      logic signed [16:0] err_prev;
      logic signed [23:0] sum;
      logic signed [15:0] cmd;
      logic signed [15:0] chan;
      logic done;
      logic [31:0] rdata;
      logic rd_code;
   } pidc_state_t;

endpackage

// file: rtl/pidc_code_mem.sv
`timescale 1ns/1ps
module pidc_code_mem #(
   parameter int unsigned DEPTH = pidc_pkg::EVENT_COUNT,
   parameter int unsigned WIDTH = pidc_pkg::CODE_W
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Write port.
   input wire logic we,
   input wire logic [$clog2(DEPTH)-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // Read port.
   input wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic [WIDTH-1:0] rdata_q
);

   logic [WIDTH-1:0] mem_q [DEPTH];

   // Each event keeps its own code; a write touches only its own entry.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_q[i] <= WIDTH'(pidc_pkg::RST_CODE);
         end
         rdata_q <= '0;
      end else begin
         if (we) begin
            mem_q[waddr] <= wdata; // [R18]
         end
         rdata_q <= mem_q[raddr];
      end
   end

endmodule

// file: sim/pidc_src_model.sv
`timescale 1ns/1ps
module pidc_src_model (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Levels asked for by the bench.
   input wire logic signed [15:0] tgt_set,
   input wire logic signed [15:0] fb_set,
   // Source outputs and the driven channel.
   output logic signed [15:0] target_value,
   output logic signed [15:0] feedback_value,
   input wire logic signed [15:0] chan_cmd,
   output logic signed [15:0] drive_q
);
   // Sources publish raw values in their own units once per clock.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         target_value <= 16'sh0000;
         feedback_value <= 16'sh0000;
         drive_q <= 16'sh0000;
      end else begin
         target_value <= tgt_set;
         feedback_value <= fb_set;
         drive_q <= chan_cmd;
      end
   end
endmodule

// file: sim/pidc_loop_assertions.sv
`timescale 1ns/1ps
module pidc_loop_chk #(
   parameter int unsigned CYC_PER_MS = 4
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Loop.
   input wire logic signed [15:0] target_value,
   input wire logic signed [15:0] feedback_value,
   input wire logic signed [15:0] chan_direct_cmd,
   input wire logic signed [15:0] pid_cmd,
   input wire logic signed [15:0] chan_cmd,
   input wire logic iter_done
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic code_wr;
   logic code_bad;
   assign code_wr = psel && penable && pwrite && paddr >= 8'h40 && paddr <= 8'h5c &&
                    paddr[1:0] == 2'h0;
   assign code_bad = pwdata[31:5] != 27'h0 || (pwdata[4:0] > 5'h15 && pwdata[4:0] != 5'h1f);
   ////////////////////////////////////////////////////////////////////////////////
   a_chan_source: assert property (chan_cmd == $past(pid_cmd) || chan_cmd == $past(chan_direct_cmd))
      else $error("channel command has no source");
   a_done_spaced: assert property (iter_done |=> !iter_done [*3])
      else $error("iterations too close");
   a_cmd_hold: assert property (iter_done |=> $stable(pid_cmd) [*3])
      else $error("command moved between iterations");
   a_cmd_moves: assert property ($changed(pid_cmd) |-> iter_done)
      else $error("command changed without iteration");
   a_cmd_range: assert property (pid_cmd <= pidc_pkg::PCT_ONE && pid_cmd >= -pidc_pkg::PCT_ONE)
      else $error("command outside full scale");
   a_code_refused: assert property (code_wr && code_bad |-> pslverr)
      else $error("illegal code accepted");
   a_code_taken: assert property (code_wr && !code_bad |-> !pslverr)
      else $error("legal code refused");
   a_reset_clear: assert property ($rose(presetn) |-> pid_cmd == 16'sh0000)
      else $error("command not cleared by reset");
   c_iter: cover property (iter_done);
   c_code_bad: cover property (code_wr && code_bad);
   c_full: cover property (iter_done && pid_cmd == pidc_pkg::PCT_ONE);
endmodule

bind pidc_loop pidc_loop_chk #(.CYC_PER_MS(CYC_PER_MS)) chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .target_value(target_value),
   .feedback_value(feedback_value), .chan_direct_cmd(chan_direct_cmd), .pid_cmd(pid_cmd),
   .chan_cmd(chan_cmd), .iter_done(iter_done));

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, iter_done, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic signed [15:0] tgt_set, fb_set, tv, fv, direct, pid_cmd, chan_cmd, drv;
   int error_cnt = 0, checked = 0, cyc = 0, iters = 0, n;
   logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h24, 8'h2c, 8'h38};
   logic [31:0] rv[8] = '{32'h0, 32'ha, 32'h0, 32'h100, 32'h0, 32'h3e8, 32'h3e8, 32'h0};
   logic [63:0] cs[9] = '{64'h0000_0100_01f4_00fa, 64'h0000_0200_03e8_0000,
      64'h0000_0100_0000_01f4, 64'h0001_0200_0000_03e8, 64'h0001_0100_00fa_01f4,
      64'h0003_0100_0000_01f4, 64'h0003_0100_01f4_0000, 64'h0004_0100_0000_01f4,
      64'h0004_0100_01f4_0000};
   logic [15:0] ce[9] = '{16'h0400, 16'h1000, 16'h0000, 16'hf000, 16'hfc00, 16'h0800,
      16'h0000, 16'h0000, 16'h0800};

   pidc_loop #(.CYC_PER_MS(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .target_value(tv), .feedback_value(fv),
      .chan_direct_cmd(direct), .pid_cmd(pid_cmd), .chan_cmd(chan_cmd), .iter_done(iter_done));
   pidc_src_model src_u (.pclk(pclk), .presetn(presetn), .tgt_set(tgt_set), .fb_set(fb_set),
      .target_value(tv), .feedback_value(fv), .chan_cmd(chan_cmd), .drive_q(drv));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic final_report;
      $display("mismatches %0d comparisons %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (iter_done === 1'b1) begin
         iters++;
      end
      if (cyc == 20000) begin
         error_cnt++;
         final_report;
      end
   end

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      chk({31'h0, er}, {31'h0, e});
   endtask

   task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic wait_iter;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (iter_done !== 1'b1 && n < 1000);
      chk({31'h0, iter_done}, 32'h1);
   endtask

   task automatic run(input logic [2:0] kind, input logic [15:0] g, t, f);
      tgt_set <= t;
      fb_set <= f;
      wr(8'h0c, {16'h0, g}, 1'b0);
      wr(8'h00, 32'h0, 1'b0);
      wr(8'h00, {26'h0, 1'b1, 1'b0, kind, 1'b1}, 1'b0);
      iters = 0;
      wait_iter;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      tgt_set = 16'sh0;
      fb_set = 16'sh0;
      direct = 16'sh0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ra[i]) rdx(ra[i], rv[i]);
      for (int i = 0; i < 9; i++) begin
         run(cs[i][50:48], cs[i][47:32], cs[i][31:16], cs[i][15:0]);
         chk({16'h0, pid_cmd}, {16'h0, ce[i]});
         @(posedge pclk);
         chk({16'h0, chan_cmd}, {16'h0, ce[i]});
      end
      wr(8'h08, 32'h500, 1'b0);
      run(3'h0, 16'h100, 16'h1f4, 16'hfa);
      chk({16'h0, pid_cmd}, 32'h0);
      rdx(8'h38, 32'h0);
      wr(8'h08, 32'h0, 1'b0);
      wr(8'h10, 32'h100, 1'b0);
      run(3'h0, 16'h100, 16'h1f4, 16'hfa);
      chk({16'h0, pid_cmd}, 32'h400);
      repeat (10) @(posedge pclk);
      wr(8'h00, 32'h0, 1'b0);
      repeat (4) @(posedge pclk);
      rdx(8'h38, 32'(1024 * iters));
      wr(8'h00, 32'h21, 1'b0);
      rdx(8'h38, 32'h0);
      wr(8'h10, 32'h0, 1'b0);
      wr(8'h18, 32'h100, 1'b0);
      wr(8'h1c, 32'h1, 1'b0);
      run(3'h1, 16'h0, 16'h4, 16'h0);
      chk({16'h0, pid_cmd}, 32'h6);
      wait_iter;
      chk({16'h0, pid_cmd}, 32'h0);
      wr(8'h18, 32'h0, 1'b0);
      wr(8'h30, 32'h7d0, 1'b0);
      run(3'h2, 16'h100, 16'h0, 16'h1f4);
      chk({16'h0, pid_cmd}, 32'h800);
      rdx(8'h00, 32'h35);
      wr(8'h04, 32'h2, 1'b0);
      wr(8'h00, 32'h1, 1'b0);
      wait_iter;
      wait_iter;
      chk(n, 32'h8);
      wr(8'h04, 32'h1, 1'b0);
      wait_iter;
      wait_iter;
      chk(n, 32'h4);
      direct <= 16'sh1234;
      repeat (3) @(posedge pclk);
      chk({16'h0, drv}, 32'h1234);
      for (int i = 0; i < 32; i++) wr(8'h5c, 32'(i), i > 21 && i < 31);
      wr(8'h40, 32'h15, 1'b0);
      wr(8'h44, 32'h20, 1'b1);
      rdx(8'h40, 32'h15);
      rdx(8'h44, 32'h0);
      rdx(8'h5c, 32'h1f);
      wr(8'h3c, 32'h5, 1'b1);
      rdx(8'h3c, 32'h0);
      final_report;
   end
endmodule
